// *** rtl/gauge_cmd_pkg.sv ***
package gauge_cmd_pkg;

  // ==========================================================================
  // Register offsets (seven-bit address space).
  // ==========================================================================
  localparam logic [6:0] ADDR_COMMAND_BYTE = 7'h00;
  localparam logic [6:0] ADDR_PRIMARY_FLAGS = 7'h01;
  localparam logic [6:0] ADDR_TEMPERATURE_AND_GAUGE = 7'h02;
  localparam logic [6:0] ADDR_AVAILABLE_CHARGE_HIGH = 7'h03;
  localparam logic [6:0] ADDR_PACK_IDENTIFIER = 7'h04;
  localparam logic [6:0] ADDR_FULL_REFERENCE = 7'h05;
  localparam logic [6:0] ADDR_SECONDARY_FLAGS = 7'h06;
  localparam logic [6:0] ADDR_PIN_PULLDOWN_DETECT = 7'h07;
  localparam logic [6:0] ADDR_PIN_PULLUP_DETECT = 7'h08;
  localparam logic [6:0] ADDR_INACCURACY_COUNT = 7'h09;
  localparam logic [6:0] ADDR_BATTERY_VOLTAGE = 7'h0b;
  localparam logic [6:0] ADDR_EMPTY_THRESHOLD_SELECT = 7'h0c;
  localparam logic [6:0] ADDR_COMPENSATED_CHARGE_HIGH = 7'h0d;
  localparam logic [6:0] ADDR_COMPENSATED_CHARGE_LOW = 7'h0e;
  localparam logic [6:0] ADDR_SCALED_ENERGY_HIGH = 7'h0f;
  localparam logic [6:0] ADDR_SCALED_ENERGY_LOW = 7'h10;
  localparam logic [6:0] ADDR_AVAILABLE_CHARGE_LOW = 7'h17;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h39;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CMD_WRITE_BIT = 7;
  localparam int SOFT_RESET_BIT = 7;
  localparam int FLAG_CHARGE_ACTIVE = 7;
  localparam int FLAG_BATTERY_REPLACED = 6;
  localparam int FLAG_CAPACITY_INACCURATE = 4;
  localparam int FLAG_VALID_DISCHARGE = 3;
  localparam int FLAG_FIRST_EMPTY = 1;
  localparam int FLAG_FINAL_EMPTY = 0;

  // ==========================================================================
  // Values after reset and counts.
  // ==========================================================================
  localparam logic [7:0] THRESHOLD_RESET = 8'h00;
  localparam logic [7:0] PACK_ID_RESET = 8'h00;
  localparam logic [7:0] INACCURACY_LIMIT = 8'h40;
  localparam logic [7:0] INACCURACY_MAX = 8'hff;
  localparam int CLK_HZ = 200_000_000;
  localparam int BLINK_HZ = 4;
  localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);
  localparam int BLINK_W = 25;

  // ==========================================================================
  // Carriers.
  // ==========================================================================
  // Events and levels reported by the counting and measuring logic.
  typedef struct packed {
    logic sense_above_qualify;
    logic discharge_active;
    logic discharge_start;
    logic valid_charge;
    logic charge_counts_256;
    logic available_at_full;
    logic full_ref_update;
    logic self_discharge_over;
    logic below_zero_c;
    logic overload;
  } gauge_events_t;

  // Register contents owned by other logic, returned on reads.
  typedef struct packed {
    logic [7:0] temperature_and_gauge;
    logic [7:0] available_charge_high;
    logic [7:0] full_reference;
    logic [7:0] secondary_flags;
    logic [7:0] pin_pulldown_detect;
    logic [7:0] pin_pullup_detect;
    logic [7:0] battery_voltage;
    logic [7:0] compensated_charge_high;
    logic [7:0] compensated_charge_low;
    logic [7:0] scaled_energy_high;
    logic [7:0] scaled_energy_low;
    logic [7:0] available_charge_low;
  } gauge_regs_t;

  // Write strobes toward the counting logic.
  typedef struct packed {
    logic available_charge_wr;
    logic full_reference_wr;
    logic [7:0] data;
  } counter_write_t;

  typedef enum logic {ST_COMMAND, ST_DATA} link_state_t;

endpackage

// *** rtl/gauge_cmd_status_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Command bit 7 picks write or read.
// - Low seven bits address; bad writes ignored.
// - Command taken only after full byte.
// - Charge flag follows qualify, cleared by discharge.
// - Replaced flag set on reset, cleared by charge.
// - Inaccurate flag at 64th charge or reset.
// - Valid discharge flag set starting from full.
// - Valid discharge cleared by four conditions.
// - First warning below threshold, under 2C, latched.
// - First warning blinks first segment at 4Hz.
// - Final warning 50mV lower, latched.
// - Final warning turns off all segments.
// - Reset register bit 7 resets device.
// - Bytes travel LSB first, slow link.
// - Break restarts interface, awaits new command.
module gauge_cmd_status_regs
  import gauge_cmd_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYCLES,
  parameter logic [7:0] FINAL_OFFSET_CODE = 8'h05
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic break_i,
  input wire gauge_events_t events_i,
  input wire gauge_regs_t regs_i,
  input wire logic display_enable_i,
  input wire logic [4:0] segment_pattern_i,
  output logic [7:0] tx_byte_o,
  output logic tx_valid_o,
  output counter_write_t counter_write_o,
  output logic soft_reset_o,
  output logic [7:0] primary_flags_o,
  output logic [7:0] empty_threshold_o,
  output logic [4:0] led_segment_o
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  // The blink counter must be able to hold the half period.
  if (BLINK_HALF < 1 || BLINK_HALF >= (1 << BLINK_W)) begin
    $error("Blink half period does not fit the counter.");
  end

  // ==========================================================================
  // Declarations
  // ==========================================================================
  link_state_t state_reg; // Waiting for a command or for write data.
  logic [6:0] addr_reg; // Target address latched from the command.
  logic [7:0] tx_byte_reg; // Byte handed to the serialiser.
  logic tx_valid_reg; // One-cycle pulse with the returned byte.
  counter_write_t cw_reg; // Write strobes to the counting logic.
  logic soft_reset_reg; // One-cycle pulse after a reset write.
  logic [7:0] pack_id_reg; // Pack identifier, kept here.
  logic [7:0] threshold_reg; // Empty threshold select, kept here.
  logic [7:0] inaccuracy_reg; // Valid charges since last update.
  logic charge_active_reg; // Primary flag bit 7.
  logic replaced_reg; // Primary flag bit 6.
  logic inaccurate_reg; // Primary flag bit 4.
  logic valid_dis_reg; // Primary flag bit 3.
  logic first_empty_reg; // Primary flag bit 1.
  logic final_empty_reg; // Primary flag bit 0.
  logic [BLINK_W-1:0] blink_cnt_reg; // Divider for the blink rate.
  logic blink_phase_reg; // Segment visible while high.
  logic [4:0] led_reg; // Registered segment drive.
  logic any_reset; // Hard reset or reset written over the link.
  logic [7:0] flags; // Assembled primary flags.
  logic first_cross; // Voltage below the first threshold.
  logic final_cross; // Voltage below the final threshold.
  logic write_cmd; // Command byte asks for a write.
  logic data_write; // Data byte arrives for a write.

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Addresses that accept a write.
  function automatic logic is_writable(input logic [6:0] a);
    is_writable = (a == ADDR_AVAILABLE_CHARGE_HIGH) ||
                  (a == ADDR_PACK_IDENTIFIER) ||
                  (a == ADDR_FULL_REFERENCE) ||
                  (a == ADDR_EMPTY_THRESHOLD_SELECT) ||
                  (a == ADDR_SOFT_RESET);
  endfunction

  // Read multiplexer; unmapped and write-only addresses return zero.
  function automatic logic [7:0] read_reg(input logic [6:0] a,
                                          input logic [7:0] fl);
    unique case (a)
      ADDR_PRIMARY_FLAGS: read_reg = fl;
      ADDR_TEMPERATURE_AND_GAUGE: read_reg = regs_i.temperature_and_gauge;
      ADDR_AVAILABLE_CHARGE_HIGH: read_reg = regs_i.available_charge_high;
      ADDR_PACK_IDENTIFIER: read_reg = pack_id_reg;
      ADDR_FULL_REFERENCE: read_reg = regs_i.full_reference;
      ADDR_SECONDARY_FLAGS: read_reg = regs_i.secondary_flags;
      ADDR_PIN_PULLDOWN_DETECT: read_reg = regs_i.pin_pulldown_detect;
      ADDR_PIN_PULLUP_DETECT: read_reg = regs_i.pin_pullup_detect;
      ADDR_INACCURACY_COUNT: read_reg = inaccuracy_reg;
      ADDR_BATTERY_VOLTAGE: read_reg = regs_i.battery_voltage;
      ADDR_EMPTY_THRESHOLD_SELECT: read_reg = threshold_reg;
      ADDR_COMPENSATED_CHARGE_HIGH: read_reg = regs_i.compensated_charge_high;
      ADDR_COMPENSATED_CHARGE_LOW: read_reg = regs_i.compensated_charge_low;
      ADDR_SCALED_ENERGY_HIGH: read_reg = regs_i.scaled_energy_high;
      ADDR_SCALED_ENERGY_LOW: read_reg = regs_i.scaled_energy_low;
      ADDR_AVAILABLE_CHARGE_LOW: read_reg = regs_i.available_charge_low;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // Combinational decode
  // ==========================================================================
  // The serialiser delivers whole bytes, assembled least significant bit
  // first, and raises the strobe only once all eight bits are in.
  always_comb begin
    any_reset = srst_i || soft_reset_reg;
    write_cmd = rx_valid_i && (state_reg == ST_COMMAND) &&
                rx_byte_i[CMD_WRITE_BIT];
    data_write = rx_valid_i && (state_reg == ST_DATA) &&
                 is_writable(addr_reg);
    // Unused positions 5 and 2 are tied to zero.
    flags = 8'h00;
    flags[FLAG_CHARGE_ACTIVE] = charge_active_reg;
    flags[FLAG_BATTERY_REPLACED] = replaced_reg;
    flags[FLAG_CAPACITY_INACCURATE] = inaccurate_reg;
    flags[FLAG_VALID_DISCHARGE] = valid_dis_reg;
    flags[FLAG_FIRST_EMPTY] = first_empty_reg;
    flags[FLAG_FINAL_EMPTY] = final_empty_reg;
    // The final threshold is compared at nine bits so the offset cannot wrap.
    first_cross = (regs_i.battery_voltage < threshold_reg) &&
                  !events_i.overload;
    final_cross = (({1'b0, regs_i.battery_voltage} +
                    {1'b0, FINAL_OFFSET_CODE}) < {1'b0, threshold_reg}) &&
                  !events_i.overload;
  end

  // ==========================================================================
  // Command sequencing
  // ==========================================================================
  // A command either returns a byte at once or waits for one data byte.
  // A break abandons any half-done write.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || break_i) begin
      state_reg <= ST_COMMAND;
      addr_reg <= 7'h00;
    end else if (rx_valid_i) begin
      unique case (state_reg)
        ST_COMMAND: begin
          addr_reg <= rx_byte_i[6:0];
          state_reg <= write_cmd ? ST_DATA : ST_COMMAND;
        end
        ST_DATA: state_reg <= ST_COMMAND;
      endcase
    end
  end

  // Read answers: one byte and a one-cycle valid pulse.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || break_i) begin
      tx_byte_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
    end else begin
      tx_valid_reg <= 1'b0;
      if (rx_valid_i && (state_reg == ST_COMMAND) &&
          !rx_byte_i[CMD_WRITE_BIT]) begin
        tx_byte_reg <= read_reg(rx_byte_i[6:0], flags);
        tx_valid_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Writable registers
  // ==========================================================================
  // Local registers take their byte; counter registers get a strobe.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pack_id_reg <= PACK_ID_RESET;
      threshold_reg <= THRESHOLD_RESET;
      cw_reg <= '0;
      soft_reset_reg <= 1'b0;
    end else begin
      cw_reg.available_charge_wr <= 1'b0;
      cw_reg.full_reference_wr <= 1'b0;
      soft_reset_reg <= 1'b0;
      if (data_write) begin
        cw_reg.data <= rx_byte_i;
        unique case (addr_reg)
          ADDR_PACK_IDENTIFIER: pack_id_reg <= rx_byte_i;
          ADDR_EMPTY_THRESHOLD_SELECT: threshold_reg <= rx_byte_i;
          ADDR_AVAILABLE_CHARGE_HIGH: cw_reg.available_charge_wr <= 1'b1;
          ADDR_FULL_REFERENCE: cw_reg.full_reference_wr <= 1'b1;
          ADDR_SOFT_RESET:
            soft_reset_reg <= rx_byte_i[SOFT_RESET_BIT];
          default: cw_reg.data <= rx_byte_i;
        endcase
      end
    end
  end

  // ==========================================================================
  // Primary status flags
  // ==========================================================================
  // Charge flag tracks the qualified sense level, held clear while discharge is active.
  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      charge_active_reg <= 1'b0;
    end else begin
      charge_active_reg <= events_i.sense_above_qualify &&
                           !events_i.discharge_active;
    end
  end

  // Valid charges since the last full-reference update, saturating.
  always_ff @(posedge sys_clk_i) begin
    if (any_reset || events_i.full_ref_update) begin
      inaccuracy_reg <= 8'h00;
    end else if (events_i.valid_charge && inaccuracy_reg != INACCURACY_MAX) begin
      inaccuracy_reg <= inaccuracy_reg + 8'h01;
    end
  end

  // Replaced and inaccurate flags; both are set by any reset.
  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      replaced_reg <= 1'b1;
      inaccurate_reg <= 1'b1;
    end else begin
      if (events_i.valid_charge &&
          (events_i.available_at_full || first_empty_reg)) begin
        replaced_reg <= 1'b0;
      end
      if (events_i.full_ref_update) begin
        inaccurate_reg <= 1'b0;
      end
      // The count reaching 64 sets the flag and wins over an update.
      if (events_i.valid_charge &&
          inaccuracy_reg == INACCURACY_LIMIT - 8'h01) begin
        inaccurate_reg <= 1'b1;
      end
    end
  end

  // Valid discharge flag; a discharge starting from full sets it, and the
  // start wins over any clearing condition in the same cycle.
  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      valid_dis_reg <= 1'b0;
    end else if (events_i.discharge_start && events_i.available_at_full) begin
      valid_dis_reg <= 1'b1;
    end else if (events_i.full_ref_update || events_i.self_discharge_over ||
                 events_i.charge_counts_256 ||
                 (first_cross && !first_empty_reg &&
                  events_i.below_zero_c)) begin
      valid_dis_reg <= 1'b0;
    end
  end

  // End-of-discharge warnings latch until a valid charge; setting wins.
  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      first_empty_reg <= 1'b0;
      final_empty_reg <= 1'b0;
    end else begin
      if (first_cross) begin
        first_empty_reg <= 1'b1;
      end else if (events_i.valid_charge) begin
        first_empty_reg <= 1'b0;
      end
      if (final_cross) begin
        final_empty_reg <= 1'b1;
      end else if (events_i.valid_charge) begin
        final_empty_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Segment drive
  // ==========================================================================
  // Divider toggling the blink phase at twice the blink rate.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || !first_empty_reg) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= 1'b1;
    end else if (blink_cnt_reg == BLINK_W'(BLINK_HALF - 1)) begin
      blink_cnt_reg <= '0;
      blink_phase_reg <= !blink_phase_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + BLINK_W'(1);
    end
  end

  // Final warning blanks everything; first warning gates segment one.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      led_reg <= 5'h00;
    end else if (final_empty_reg || !display_enable_i) begin
      led_reg <= 5'h00;
    end else begin
      led_reg <= segment_pattern_i;
      led_reg[0] <= segment_pattern_i[0] &&
                    (!first_empty_reg || blink_phase_reg);
    end
  end

  assign tx_byte_o = tx_byte_reg;
  assign tx_valid_o = tx_valid_reg;
  assign counter_write_o = cw_reg;
  assign soft_reset_o = soft_reset_reg;
  assign primary_flags_o = flags;
  assign empty_threshold_o = threshold_reg;
  assign led_segment_o = led_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_READ_ANSWERS: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rx_valid_i && !break_i && state_reg == ST_COMMAND && !rx_byte_i[7])
    |=> tx_valid_o && tx_byte_o == $past(read_reg(rx_byte_i[6:0], flags)))
    else $error("Read command did not answer next cycle.");
  AST_WRITE_WAITS: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (write_cmd && !break_i) |=> state_reg == ST_DATA && !tx_valid_o)
    else $error("Write command did not wait for data.");
  AST_BAD_WRITE_IGNORED: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rx_valid_i && state_reg == ST_DATA && !is_writable(addr_reg))
    |=> $stable(pack_id_reg) && $stable(threshold_reg) && !soft_reset_o)
    else $error("Write to invalid address had an effect.");
  AST_ANSWER_NEEDS_BYTE: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    tx_valid_o |-> $past(rx_valid_i))
    else $error("Answer without a received byte.");
  AST_CHARGE_FLAG: assert property (
    @(posedge sys_clk_i) disable iff (any_reset)
    events_i.discharge_active |=> !flags[FLAG_CHARGE_ACTIVE])
    else $error("Charge flag set during discharge.");
  AST_RESET_FLAGS: assert property (
    @(posedge sys_clk_i)
    soft_reset_o |=> flags[FLAG_BATTERY_REPLACED] &&
                     flags[FLAG_CAPACITY_INACCURATE] &&
                     !flags[FLAG_FIRST_EMPTY])
    else $error("Reset did not set replaced and inaccurate flags.");
  AST_VALID_DIS_CLEAR: assert property (
    @(posedge sys_clk_i) disable iff (any_reset)
    (events_i.self_discharge_over && !events_i.discharge_start)
    |=> !flags[FLAG_VALID_DISCHARGE])
    else $error("Valid discharge flag not cleared.");
  AST_FIRST_WARN: assert property (
    @(posedge sys_clk_i) disable iff (any_reset)
    first_cross |=> flags[FLAG_FIRST_EMPTY])
    else $error("First warning not raised below threshold.");
  AST_SEG_OFF: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    final_empty_reg |=> led_segment_o == 5'h00)
    else $error("Segments driven during final warning.");
  AST_UNUSED_ZERO: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (tx_valid_o && $past(rx_byte_i[6:0]) == ADDR_PRIMARY_FLAGS)
    |-> tx_byte_o[5] == 1'b0 && tx_byte_o[2] == 1'b0)
    else $error("Unused flag bits read nonzero.");

endmodule

// *** tb/gauge_cmd_status_regs_bench.sv ***
`timescale 1ns/1ps
// ==========================================
// Bench: command sequences with expected results.
module gauge_cmd_status_regs_bench;
  import gauge_cmd_pkg::*;
  localparam int HALF = 4;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] rx_byte, tx_byte, flags, thr, rd;
  logic rx_valid, brk, tx_valid, soft_rst, s0;
  gauge_events_t ev = '0;
  gauge_regs_t regs = '{temperature_and_gauge: 8'h5a,
                        battery_voltage: 8'h80, default: 8'h00};
  logic disp_en = 1'b1;
  logic [4:0] seg_pat = 5'h1f;
  counter_write_t cw;
  logic [4:0] leds;
  int failures = 0;
  int n_tests = 0;
  // 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;
  gauge_host_model host_u (.sys_clk_i(sys_clk), .tx_byte_i(tx_byte),
    .tx_valid_i(tx_valid), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .break_o(brk));
  gauge_cmd_status_regs #(.BLINK_HALF(HALF)) dut_u (.sys_clk_i(sys_clk),
    .srst_i(srst), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
    .break_i(brk), .events_i(ev), .regs_i(regs),
    .display_enable_i(disp_en), .segment_pattern_i(seg_pat),
    .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .counter_write_o(cw),
    .soft_reset_o(soft_rst), .primary_flags_o(flags),
    .empty_threshold_o(thr), .led_segment_o(leds));
  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits n edges, then steps just past the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
  // Main sequence.
  initial begin
    cyc(2);
    srst = 1'b0;
    host_u.read_reg(ADDR_PRIMARY_FLAGS, rd);
    check("flags", rd, 8'h50);
    check("threshold", thr, THRESHOLD_RESET);
    host_u.read_reg(7'h7f, rd);
    check("unmapped", rd, 8'h00);
    $display("test reset done");
    host_u.write_reg(ADDR_EMPTY_THRESHOLD_SELECT, 8'h20);
    cyc(2);
    check("threshold", thr, 8'h20);
    host_u.write_reg(ADDR_PACK_IDENTIFIER, 8'ha5);
    host_u.read_reg(ADDR_PACK_IDENTIFIER, rd);
    check("pack id", rd, 8'ha5);
    host_u.write_reg(ADDR_TEMPERATURE_AND_GAUGE, 8'h00);
    host_u.read_reg(ADDR_TEMPERATURE_AND_GAUGE, rd);
    check("temperature", rd, 8'h5a);
    host_u.write_reg(ADDR_FULL_REFERENCE, 8'h33);
    check("ref strobe", {7'h00, cw.full_reference_wr}, 8'h01);
    cyc(2);
    check("counter data", cw.data, 8'h33);
    host_u.write_reg(ADDR_AVAILABLE_CHARGE_HIGH, 8'h44);
    check("charge strobe", {7'h00, cw.available_charge_wr}, 8'h01);
    check("counter data", cw.data, 8'h44);
    // A break drops the pending write; the next byte is a command.
    host_u.send_byte(8'h8c);
    host_u.send_break();
    host_u.read_reg(7'h44, rd);
    check("after break", rd, 8'h00);
    check("threshold", thr, 8'h20);
    $display("test access done");
    ev.available_at_full = 1'b1;
    ev.valid_charge = 1'b1;
    cyc(1);
    ev.valid_charge = 1'b0;
    ev.full_ref_update = 1'b1;
    cyc(1);
    ev.full_ref_update = 1'b0;
    cyc(1);
    check("flags", flags, 8'h00);
    // Sixty-three charges leave the flag clear; the next one sets it.
    repeat (63) begin
      ev.valid_charge = 1'b1;
      cyc(1);
      ev.valid_charge = 1'b0;
      cyc(1);
    end
    check("flags", flags, 8'h00);
    ev.valid_charge = 1'b1;
    cyc(1);
    ev.valid_charge = 1'b0;
    cyc(1);
    check("flags", flags, 8'h10);
    host_u.read_reg(ADDR_INACCURACY_COUNT, rd);
    check("inaccuracy count", rd, INACCURACY_LIMIT);
    ev.full_ref_update = 1'b1;
    cyc(1);
    ev.full_ref_update = 1'b0;
    ev.discharge_start = 1'b1;
    cyc(1);
    ev.discharge_start = 1'b0;
    cyc(1);
    check("flags", flags, 8'h08);
    ev.self_discharge_over = 1'b1;
    cyc(2);
    check("flags", flags, 8'h00);
    ev.self_discharge_over = 1'b0;
    // A long valid charge also clears the flag once it is set again.
    ev.discharge_start = 1'b1;
    cyc(1);
    ev.discharge_start = 1'b0;
    ev.charge_counts_256 = 1'b1;
    check("flags", flags, 8'h08);
    cyc(1);
    ev.charge_counts_256 = 1'b0;
    check("flags", flags, 8'h00);
    ev.available_at_full = 1'b0;
    ev.sense_above_qualify = 1'b1;
    cyc(2);
    check("flags", flags, 8'h80);
    ev.discharge_active = 1'b1;
    cyc(2);
    check("flags", flags, 8'h00);
    ev.sense_above_qualify = 1'b0;
    ev.discharge_active = 1'b0;
    $display("test flags done");
    // Disabling the display blanks every segment.
    disp_en = 1'b0;
    cyc(2);
    check("leds", {3'h0, leds}, 8'h00);
    disp_en = 1'b1;
    cyc(2);
    check("leds", {3'h0, leds}, 8'h1f);
    regs.battery_voltage = 8'h1f;
    cyc(2);
    check("flags", flags, 8'h02);
    s0 = leds[0];
    cyc(HALF);
    check("blink", {7'h00, leds[0]}, {7'h00, ~s0});
    regs.battery_voltage = 8'h10;
    cyc(2);
    check("flags", flags, 8'h03);
    check("leds", {3'h0, leds}, 8'h00);
    regs.battery_voltage = 8'h80;
    ev.valid_charge = 1'b1;
    cyc(1);
    ev.valid_charge = 1'b0;
    cyc(1);
    check("flags", flags, 8'h00);
    $display("test warnings done");
    host_u.write_reg(ADDR_SOFT_RESET, 8'h80);
    for (int i = 0; i < 4 && soft_rst !== 1'b1; i++) cyc(1);
    check("soft reset", {7'h00, soft_rst}, 8'h01);
    cyc(2);
    check("flags", flags, 8'h50);
    check("threshold", thr, 8'h20);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule

// *** tb/gauge_host_model.sv ***
`timescale 1ns/1ps
// ==========================================
// Host model: sends whole bytes and collects the device's answers.
module gauge_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic tx_valid_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic break_o
);
  // Idle levels at time zero.
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
    break_o = 1'b0;
  end
  // One byte per pulse; the idle lines show the inverse of the last byte.
  task automatic send_byte(input logic [7:0] b);
    @(posedge sys_clk_i);
    #1;
    rx_byte_o = b;
    rx_valid_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    rx_valid_o = 1'b0;
    rx_byte_o = ~b;
  endtask
  // A break pulse restarts the command sequence.
  task automatic send_break();
    @(posedge sys_clk_i);
    #1;
    break_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    break_o = 1'b0;
  endtask
  // Bit 7 high selects a write; the data byte follows.
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    send_byte({1'b1, a});
    send_byte(d);
  endtask
  // Bit 7 low selects a read; the answer is awaited for a bounded time.
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    int i;
    send_byte({1'b0, a});
    for (i = 0; i < 8 && tx_valid_i !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    d = (tx_valid_i === 1'b1) ? tx_byte_i : 8'hxx;
  endtask
endmodule
